// file: rtl/sss_pkg.sv
// sss_pkg: register map, field layout, reset values and types of the
// sensor scan sequencer.
// assumes one system clock and the plain register port of sss_scan_seq.
`default_nettype none
package sss_pkg;
	// ==========================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_TIMING = 8'h08;
	localparam logic [7:0] OFS_PTOP = 8'h0C;
	localparam logic [7:0] OFS_CHANNEL_ENABLE_MASK = 8'h10;
	localparam logic [7:0] OFS_SRES = 8'h14;
	localparam logic [7:0] OFS_FLAGS = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_IDLE = 8'h20;
	localparam logic [7:0] OFS_ALT = 8'h24;
	localparam logic [7:0] OFS_CLKDIV = 8'h28;
	localparam logic [7:0] OFS_RESULT = 8'h2C;
	// per-channel groups: addr[7:6] picks the group, addr[5:2] the channel
	localparam logic [1:0] GRP_CHT = 2'h1;
	localparam logic [1:0] GRP_CHI = 2'h2;
	localparam logic [1:0] GRP_CHE = 2'h3;

	// ==========================================
	// field positions
	localparam int CTRL_TRIG = 0;
	localparam int CTRL_ALTMAP = 2;
	localparam int CTRL_PAIRED = 3;
	localparam int CTRL_EVSEL = 4;
	localparam int CMD_START = 0;
	localparam int TIM_PPRESC = 0;
	localparam int TIM_SPRESC = 4;
	localparam int TIM_FPRESC = 8;
	localparam int TIM_SDLY = 12;
	localparam int CLK_SLOWDIV = 0;
	localparam int CLK_TICKPRE = 16;
	localparam int CLK_AUXDIV = 18;
	localparam int CHT_EXLEN = 0;
	localparam int CHT_MDLY = 8;
	localparam int CHT_SDLY = 16;
	localparam int CHT_EXCITE_CLOCK_SELECT = 24;
	localparam int CHT_SMPCLK = 25;
	localparam int CHI_EXCITE_PIN_MODE = 0;
	localparam int CHI_ALTERNATE_EXCITE = 2;
	localparam int CHI_CNTEVAL = 3;
	localparam int CHI_RAISE = 4;
	localparam int CHI_GE = 5;
	localparam int ALT_ALWAYS = 16;

	// ==========================================
	// reset values and encodings
	localparam logic [6:0] RST_CTRL = 7'h00;
	localparam logic [15:0] RST_TIMING = 16'h0000;
	localparam logic [15:0] RST_PTOP = 16'h000F;
	localparam logic [29:0] RST_CLKDIV = 30'h00000261;
	localparam logic [15:0] DAC_OK = 16'hF00F;
	localparam logic [1:0] TRIG_PERIODIC = 2'h0;
	localparam logic [1:0] TRIG_SINGLE = 2'h1;
	localparam logic [1:0] TRIG_REFLEX = 2'h2;
	localparam logic [1:0] PM_DISABLED = 2'h0;
	localparam logic [1:0] PM_HIGH = 2'h1;
	localparam logic [1:0] PM_LOW = 2'h2;
	localparam logic [1:0] PM_DAC = 2'h3;

	// ==========================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE, ST_START_DLY, ST_EXCITE, ST_TRISTATE, ST_MEASURE, ST_EVAL
	} sss_state_t;
	typedef struct packed {
		logic [15:0] level;
		logic [15:0] oe_n;
		logic [15:0] dac_en;
	} sss_ch_pins_t;
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] oe_n;
	} sss_alt_pins_t;
	typedef struct packed {
		logic oe_n;
		logic level;
		logic dac;
	} sss_drive_t;
endpackage
`default_nettype wire

// file: rtl/sss_scan_seq.sv
// sss_scan_seq: autonomous sensor scan sequencer with register port.
// assumes comparator outputs and event lines are asynchronous; the slow
// tick and fast oscillator rates are enables divided from i_clk_sys.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module sss_scan_seq (
	input wire logic i_clk_sys, // 20 MHz system clock
	input wire logic i_reset, // synchronous, active high
	input wire logic [7:0] i_addr, // register byte address
	input wire logic [31:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [31:0] o_rdata, // read data, cycle after i_rd
	input wire logic [1:0] i_cmp_out, // comparator 1 and 0 outputs
	input wire logic [7:0] i_reflex_event, // reflex event channels
	output var sss_pkg::sss_ch_pins_t o_ch_pins, // channel pin drive
	output var sss_pkg::sss_alt_pins_t o_alt_pins, // dedicated alt pins
	output logic [2:0] o_cmp_sel, // comparator input select
	output logic [1:0] o_cmp_en, // comparators in use
	output logic [1:0] o_dac_req, // DAC channel 1 and 0 wanted
	output logic [15:0] o_scan_result, // scan result vector
	output logic [15:0] o_flags, // channel flags
	output logic o_busy // scan in progress
);
	// ==========================================
	// functions
	// step due when the prescaler's low p bits are all ones
	function automatic logic step_due(input logic [15:0] cnt, input logic [3:0] p);
		logic [15:0] mask;
		mask = 16'((32'h1 << p) - 32'h1);
		return (cnt & mask) == mask;
	endfunction

	// lowest enabled channel at or above from, 16 when none
	function automatic logic [4:0] next_en(input logic [15:0] m, input logic [4:0] from);
		logic [4:0] res;
		res = 5'h10;
		for (int i = 15; i >= 0; i--) begin
			if (m[i] && (5'(i) >= from)) begin
				res = 5'(i);
			end
		end
		return res;
	endfunction

	// pin drive for a mode; DAC only where the pin can reach one
	function automatic sss_pkg::sss_drive_t pin_drive(input logic [1:0] mode,
			input logic dac_ok);
		sss_pkg::sss_drive_t d;
		d = '{oe_n: 1'b1, level: 1'b0, dac: 1'b0};
		case (mode)
			sss_pkg::PM_HIGH: begin
				d = '{oe_n: 1'b0, level: 1'b1, dac: 1'b0};
			end
			sss_pkg::PM_LOW: begin
				d.oe_n = 1'b0;
			end
			sss_pkg::PM_DAC: begin
				d.dac = dac_ok;
			end
			default: begin
				d.oe_n = 1'b1;
			end
		endcase
		return d;
	endfunction

	// ==========================================
	// registers and state
	logic [6:0] r_ctrl;
	logic [15:0] r_timing, r_ptop, r_channel_enable_mask;
	logic [31:0] r_idle;
	logic [23:0] r_alt;
	logic [29:0] r_clkdiv;
	logic [25:0] r_cht [16];
	logic [5:0] r_chi [16];
	logic [15:0] r_che [16];
	logic [15:0] last_result;
	logic [9:0] sync1, sync2, sync3;
	logic [15:0] slow_div, tick_pre, slow_pre, fast_pre, pc_pre, pc_cnt;
	logic [11:0] aux_div;
	logic slow_a_en, aux_en, pc_expire, armed, pend_extra, pend_periodic;
	sss_pkg::sss_state_t state;
	logic [3:0] cur_ch;
	logic [7:0] tmr, gate_cnt;
	logic [15:0] pulse_cnt;
	logic [1:0] samp;
	logic tick_en, slow_step, fast_step, pc_step, ex_step, sm_step;
	logic [1:0] trig_mode;
	logic start_cmd, ev_rise, launch, paired, comp, cmp_rise, gate_open, trig;
	logic [15:0] scan_mask, res_mask, res_val, flag_set, flag_clr, eval_word;
	logic [4:0] first_ch, nxt_ch;
	logic [25:0] cht;
	logic [5:0] chi;
	logic [1:0] excite_pin_mode;
	logic alternate_excite, in_scan;
	sss_pkg::sss_drive_t d;
	sss_pkg::sss_ch_pins_t next_ch_pins;
	sss_pkg::sss_alt_pins_t next_alt_pins;
	logic [31:0] rd_val;

	// ==========================================
	// input synchronisers: sync1 feeds only sync2
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			sync1 <= 10'h000;
			sync2 <= 10'h000;
			sync3 <= 10'h000;
		end else begin
			sync1 <= {i_reflex_event, i_cmp_out};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// ==========================================
	// rate dividers: slow clock, sensor tick, fast oscillator
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			slow_div <= 16'h0000;
			slow_a_en <= 1'b0;
		end else if (slow_div >= r_clkdiv[sss_pkg::CLK_SLOWDIV +: 16]) begin
			slow_div <= 16'h0000;
			slow_a_en <= 1'b1;
		end else begin
			slow_div <= slow_div + 16'h0001;
			slow_a_en <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			aux_div <= 12'h000;
			aux_en <= 1'b0;
		end else if (aux_div >= r_clkdiv[sss_pkg::CLK_AUXDIV +: 12]) begin
			aux_div <= 12'h000;
			aux_en <= 1'b1;
		end else begin
			aux_div <= aux_div + 12'h001;
			aux_en <= 1'b0;
		end
	end

	// step enables of the prescaled timers
	assign tick_en = slow_a_en && step_due(tick_pre, {2'h0, r_clkdiv[sss_pkg::CLK_TICKPRE +: 2]});
	assign slow_step = tick_en && step_due(slow_pre, r_timing[sss_pkg::TIM_SPRESC +: 4]);
	assign fast_step = aux_en && step_due(fast_pre, r_timing[sss_pkg::TIM_FPRESC +: 4]);
	assign pc_step = tick_en && step_due(pc_pre, r_timing[sss_pkg::TIM_PPRESC +: 4]);

	// free-running prescaler counters
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			tick_pre <= 16'h0000;
			slow_pre <= 16'h0000;
			pc_pre <= 16'h0000;
			fast_pre <= 16'h0000;
		end else begin
			if (slow_a_en) begin
				tick_pre <= tick_pre + 16'h0001;
			end
			if (tick_en) begin
				slow_pre <= slow_pre + 16'h0001;
				pc_pre <= pc_pre + 16'h0001;
			end
			if (aux_en) begin
				fast_pre <= fast_pre + 16'h0001;
			end
		end
	end

	// period counter wraps at top: one expiry per (1 + top) steps
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			pc_cnt <= 16'h0000;
			pc_expire <= 1'b0;
		end else begin
			pc_expire <= 1'b0;
			if (pc_step) begin
				if (pc_cnt >= r_ptop) begin
					pc_cnt <= 16'h0000;
					pc_expire <= 1'b1;
				end else begin
					pc_cnt <= pc_cnt + 16'h0001;
				end
			end
		end
	end

	// ==========================================
	// scan triggers
	assign trig_mode = r_ctrl[sss_pkg::CTRL_TRIG +: 2];
	assign start_cmd = i_wr && (i_addr == sss_pkg::OFS_CMD) && i_wdata[sss_pkg::CMD_START];
	assign ev_rise = sync2[2 + 32'(r_ctrl[sss_pkg::CTRL_EVSEL +: 3])]
		&& !sync3[2 + 32'(r_ctrl[sss_pkg::CTRL_EVSEL +: 3])];
	assign launch = (state == sss_pkg::ST_IDLE) && (pend_extra || pend_periodic);

	// pending requests; a new request wins over the launch that clears
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			armed <= 1'b0;
			pend_extra <= 1'b0;
			pend_periodic <= 1'b0;
		end else begin
			armed <= (trig_mode == sss_pkg::TRIG_REFLEX) && (armed || start_cmd);
			pend_extra <= (pend_extra && !launch)
				|| (start_cmd && (trig_mode != sss_pkg::TRIG_REFLEX))
				|| (armed && ev_rise && (trig_mode == sss_pkg::TRIG_REFLEX));
			pend_periodic <= (pend_periodic && !launch)
				|| (pc_expire && (trig_mode == sss_pkg::TRIG_PERIODIC));
		end
	end

	// ==========================================
	// active channel configuration
	assign cht = r_cht[cur_ch];
	assign chi = r_chi[cur_ch];
	assign excite_pin_mode = chi[sss_pkg::CHI_EXCITE_PIN_MODE +: 2];
	assign alternate_excite = chi[sss_pkg::CHI_ALTERNATE_EXCITE];
	assign ex_step = cht[sss_pkg::CHT_EXCITE_CLOCK_SELECT] ? fast_step : slow_step;
	assign sm_step = cht[sss_pkg::CHT_SMPCLK] ? fast_step : slow_step;
	assign paired = r_ctrl[sss_pkg::CTRL_PAIRED];
	assign scan_mask = paired ? {8'h00, r_channel_enable_mask[7:0] | r_channel_enable_mask[15:8]} : r_channel_enable_mask;
	assign first_ch = next_en(scan_mask, 5'h00);
	assign nxt_ch = next_en(scan_mask, {1'b0, cur_ch} + 5'h01);
	assign comp = cur_ch[3];
	assign cmp_rise = sync2[comp] && !sync3[comp];
	assign gate_open = gate_cnt >= cht[sss_pkg::CHT_MDLY +: 8];
	assign in_scan = state != sss_pkg::ST_IDLE;

	// ==========================================
	// channel sequencer
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state <= sss_pkg::ST_IDLE;
			cur_ch <= 4'h0;
			tmr <= 8'h00;
			gate_cnt <= 8'h00;
			pulse_cnt <= 16'h0000;
			samp <= 2'h0;
		end else begin
			case (state)
				sss_pkg::ST_IDLE: begin
					if (launch && !first_ch[4]) begin
						cur_ch <= first_ch[3:0];
						tmr <= 8'h00;
						state <= sss_pkg::ST_START_DLY;
					end
				end
				sss_pkg::ST_START_DLY: begin
					if (tmr >= {4'h0, r_timing[sss_pkg::TIM_SDLY +: 4]}) begin
						tmr <= 8'h00;
						state <= sss_pkg::ST_EXCITE;
					end else if (slow_step) begin
						tmr <= tmr + 8'h01;
					end
				end
				sss_pkg::ST_EXCITE: begin
					if (tmr >= cht[sss_pkg::CHT_EXLEN +: 8]) begin
						tmr <= 8'h00;
						state <= sss_pkg::ST_TRISTATE;
					end else if (ex_step) begin
						tmr <= tmr + 8'h01;
					end
				end
				sss_pkg::ST_TRISTATE: begin
					if (ex_step) begin
						gate_cnt <= 8'h00;
						pulse_cnt <= 16'h0000;
						state <= sss_pkg::ST_MEASURE;
					end
				end
				sss_pkg::ST_MEASURE: begin
					if (!gate_open && ex_step) begin
						gate_cnt <= gate_cnt + 8'h01;
					end
					if (gate_open && cmp_rise && (pulse_cnt != 16'hFFFF)) begin
						pulse_cnt <= pulse_cnt + 16'h0001;
					end
					if (tmr >= cht[sss_pkg::CHT_SDLY +: 8]) begin
						samp <= gate_open ? sync2[1:0] : 2'h0;
						state <= sss_pkg::ST_EVAL;
					end else if (sm_step) begin
						tmr <= tmr + 8'h01;
					end
				end
				sss_pkg::ST_EVAL: begin
					tmr <= 8'h00;
					if (nxt_ch[4]) begin
						state <= sss_pkg::ST_IDLE;
					end else begin
						cur_ch <= nxt_ch[3:0];
						state <= sss_pkg::ST_START_DLY;
					end
				end
				default: begin
					state <= sss_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// evaluation of the finished channel
	always_comb begin
		res_mask = 16'h0000;
		res_val = 16'h0000;
		eval_word = 16'h0000;
		trig = 1'b0;
		if (state == sss_pkg::ST_EVAL) begin
			if (paired) begin
				res_mask[{1'b0, cur_ch[2:0]}] = 1'b1;
				res_mask[{1'b1, cur_ch[2:0]}] = 1'b1;
				res_val[{1'b0, cur_ch[2:0]}] = samp[0];
				res_val[{1'b1, cur_ch[2:0]}] = samp[1];
				eval_word = {14'h0000, samp};
			end else begin
				if (chi[sss_pkg::CHI_CNTEVAL]) begin
					trig = chi[sss_pkg::CHI_GE] ? (pulse_cnt >= r_che[cur_ch])
						: (pulse_cnt < r_che[cur_ch]);
					eval_word = pulse_cnt;
				end else begin
					trig = samp[comp];
					eval_word = {15'h0000, samp[comp]};
				end
				res_mask[cur_ch] = 1'b1;
				res_val[cur_ch] = trig;
			end
		end
		flag_set = chi[sss_pkg::CHI_RAISE] ? (res_mask & res_val) : 16'h0000;
	end

	assign flag_clr = (i_wr && (i_addr == sss_pkg::OFS_FLAGS)) ? i_wdata[15:0] : 16'h0000;

	// result vector, sticky flags (set beats clear), last stored result
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_scan_result <= 16'h0000;
			o_flags <= 16'h0000;
			last_result <= 16'h0000;
		end else begin
			o_scan_result <= (o_scan_result & ~res_mask) | res_val;
			o_flags <= (o_flags & ~flag_clr) | flag_set;
			if (state == sss_pkg::ST_EVAL) begin
				last_result <= eval_word;
			end
		end
	end

	// ==========================================
	// pin sequencing
	always_comb begin
		next_ch_pins = '0;
		next_alt_pins = '0;
		d = '0;
		for (int i = 0; i < 16; i++) begin
			d = pin_drive(r_idle[2 * i +: 2], sss_pkg::DAC_OK[i]);
			if (in_scan && (4'(i) == cur_ch)) begin
				if (state == sss_pkg::ST_EXCITE && !alternate_excite) begin
					d = pin_drive(excite_pin_mode, sss_pkg::DAC_OK[i]);
				end else if ((state == sss_pkg::ST_TRISTATE && !alternate_excite)
						|| state == sss_pkg::ST_MEASURE || state == sss_pkg::ST_EVAL) begin
					d = pin_drive(sss_pkg::PM_DISABLED, 1'b0);
				end
			end
			if (paired && (state == sss_pkg::ST_MEASURE) && (4'(i) == {1'b1, cur_ch[2:0]})) begin
				d = pin_drive(sss_pkg::PM_DISABLED, 1'b0);
			end
			if ((state == sss_pkg::ST_EXCITE) && alternate_excite && !r_ctrl[sss_pkg::CTRL_ALTMAP]
					&& (4'(i) == (cur_ch ^ 4'h8))) begin
				d = pin_drive(excite_pin_mode, sss_pkg::DAC_OK[i]);
			end
			next_ch_pins.level[i] = d.level;
			next_ch_pins.oe_n[i] = d.oe_n;
			next_ch_pins.dac_en[i] = d.dac;
		end
		for (int j = 0; j < 8; j++) begin
			d = pin_drive(r_alt[2 * j +: 2], 1'b0);
			if ((state == sss_pkg::ST_EXCITE) && alternate_excite && r_ctrl[sss_pkg::CTRL_ALTMAP]
					&& ((3'(j) == cur_ch[2:0]) || r_alt[sss_pkg::ALT_ALWAYS + j])) begin
				d = pin_drive(excite_pin_mode, 1'b0);
			end
			next_alt_pins.level[j] = d.level;
			next_alt_pins.oe_n[j] = d.oe_n;
		end
	end

	// registered pin, comparator and DAC controls
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_ch_pins <= '{level: 16'h0000, oe_n: 16'hFFFF, dac_en: 16'h0000};
			o_alt_pins <= '{level: 8'h00, oe_n: 8'hFF};
			o_cmp_sel <= 3'h0;
			o_cmp_en <= 2'h0;
			o_dac_req <= 2'h0;
			o_busy <= 1'b0;
		end else begin
			o_ch_pins <= next_ch_pins;
			o_alt_pins <= next_alt_pins;
			o_cmp_sel <= cur_ch[2:0];
			o_cmp_en <= !in_scan ? 2'h0 : (paired ? 2'h3 : (comp ? 2'h2 : 2'h1));
			o_dac_req <= {|next_ch_pins.dac_en[15:12], |next_ch_pins.dac_en[3:0]};
			o_busy <= in_scan;
		end
	end

	// ==========================================
	// register writes
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			r_ctrl <= sss_pkg::RST_CTRL;
			r_timing <= sss_pkg::RST_TIMING;
			r_ptop <= sss_pkg::RST_PTOP;
			r_channel_enable_mask <= 16'h0000;
			r_idle <= 32'h00000000;
			r_alt <= 24'h000000;
			r_clkdiv <= sss_pkg::RST_CLKDIV;
			for (int k = 0; k < 16; k++) begin
				r_cht[k] <= 26'h0000000;
				r_chi[k] <= 6'h00;
				r_che[k] <= 16'h0000;
			end
		end else if (i_wr) begin
			case (i_addr[7:6])
				sss_pkg::GRP_CHT: r_cht[i_addr[5:2]] <= i_wdata[25:0];
				sss_pkg::GRP_CHI: r_chi[i_addr[5:2]] <= i_wdata[5:0];
				sss_pkg::GRP_CHE: r_che[i_addr[5:2]] <= i_wdata[15:0];
				default: begin
					case (i_addr)
						sss_pkg::OFS_CTRL: r_ctrl <= i_wdata[6:0];
						sss_pkg::OFS_TIMING: r_timing <= i_wdata[15:0];
						sss_pkg::OFS_PTOP: r_ptop <= i_wdata[15:0];
						sss_pkg::OFS_CHANNEL_ENABLE_MASK: r_channel_enable_mask <= i_wdata[15:0];
						sss_pkg::OFS_IDLE: r_idle <= i_wdata;
						sss_pkg::OFS_ALT: r_alt <= i_wdata[23:0];
						sss_pkg::OFS_CLKDIV: r_clkdiv <= i_wdata[29:0];
						default: r_ctrl <= r_ctrl;
					endcase
				end
			endcase
		end
	end

	// read decode; unmapped addresses read zero
	always_comb begin
		rd_val = 32'h00000000;
		case (i_addr[7:6])
			sss_pkg::GRP_CHT: rd_val = 32'(r_cht[i_addr[5:2]]);
			sss_pkg::GRP_CHI: rd_val = 32'(r_chi[i_addr[5:2]]);
			sss_pkg::GRP_CHE: rd_val = 32'(r_che[i_addr[5:2]]);
			default: begin
				case (i_addr)
					sss_pkg::OFS_CTRL: rd_val = 32'(r_ctrl);
					sss_pkg::OFS_TIMING: rd_val = 32'(r_timing);
					sss_pkg::OFS_PTOP: rd_val = 32'(r_ptop);
					sss_pkg::OFS_CHANNEL_ENABLE_MASK: rd_val = 32'(r_channel_enable_mask);
					sss_pkg::OFS_SRES: rd_val = 32'(o_scan_result);
					sss_pkg::OFS_FLAGS: rd_val = 32'(o_flags);
					sss_pkg::OFS_STATUS: rd_val = 32'({cur_ch, 3'(state), pend_periodic,
						pend_extra, armed, o_busy});
					sss_pkg::OFS_IDLE: rd_val = r_idle;
					sss_pkg::OFS_ALT: rd_val = 32'(r_alt);
					sss_pkg::OFS_CLKDIV: rd_val = 32'(r_clkdiv);
					sss_pkg::OFS_RESULT: rd_val = 32'(last_result);
					default: rd_val = 32'h00000000;
				endcase
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_rdata <= 32'h00000000;
		end else begin
			o_rdata <= i_rd ? rd_val : 32'h00000000;
		end
	end
endmodule

`default_nettype wire

// file: tb/sss_cmp_model.sv
// sss_cmp_model: behavioural pair of analog comparators on the far side.
// assumes i_levels holds one output per channel, 8-15 on comparator 1.
`timescale 1ns/1ns
`default_nettype none
module sss_cmp_model (
	input wire logic i_clk_sys, // system clock
	input wire logic [2:0] i_sel, // input select
	input wire logic [1:0] i_en, // comparators powered
	input wire logic [15:0] i_levels, // output per channel
	input wire logic i_pulse, // oscillating sensor
	output logic [1:0] o_out // comparator outputs
);
	logic [1:0] phase = 2'h0;
	// free phase: pulse train and the wander of an unpowered comparator
	always @(posedge i_clk_sys) begin
		phase <= phase + 2'h1;
	end
	// comparator k watches channel k*8+sel
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			if (!i_en[k]) o_out[k] = phase[0];
			else if (i_pulse) o_out[k] = phase[1];
			else o_out[k] = i_levels[{k[0], i_sel}];
		end
	end
endmodule
`default_nettype wire

// file: tb/sss_scan_seq_chk.sv
// sss_scan_seq_chk: port assertions for the sensor scan sequencer.
// assumes a bind to sss_scan_seq; shadows follow the register write port.
`timescale 1ns/1ns
`default_nettype none
module sss_scan_seq_chk (
	input wire logic i_clk_sys, // system clock
	input wire logic i_reset, // sync reset
	input wire logic [7:0] i_addr, // address
	input wire logic [31:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire sss_pkg::sss_ch_pins_t o_ch_pins, // channel pins
	input wire logic [1:0] o_cmp_en, // comparators in use
	input wire logic [15:0] o_scan_result, // result vector
	input wire logic [15:0] o_flags, // flags
	input wire logic o_busy // busy
);
	logic [15:0] channel_enable_mask;
	logic [3:0] ctrl;
	logic start;
	logic [15:0] ok;
	// ==========================================
	// shadows of the enable mask and control
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			channel_enable_mask <= 16'h0000;
			ctrl <= 4'h0;
		end else if (i_wr && i_addr == sss_pkg::OFS_CHANNEL_ENABLE_MASK) begin
			channel_enable_mask <= i_wdata[15:0];
		end else if (i_wr && i_addr == sss_pkg::OFS_CTRL) begin
			ctrl <= i_wdata[3:0];
		end
	end
	// start write, and result bits allowed to rise
	assign start = i_wr && i_addr == sss_pkg::OFS_CMD && i_wdata[0];
	assign ok = channel_enable_mask | (ctrl[3] ? {2{channel_enable_mask[7:0] | channel_enable_mask[15:8]}} : 16'h0000);
	// ==========================================
	// assertions
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	AST_DAC_CH: assert property ((o_ch_pins.dac_en & ~sss_pkg::DAC_OK) == 16'h0000)
		else $error("DAC drive on a channel without DAC");
	AST_SKIP: assert property (((o_scan_result & ~$past(o_scan_result)) & ~ok) == 16'h0000)
		else $error("result set for a disabled channel");
	AST_RES_BUSY: assert property ($changed(o_scan_result) |-> o_busy || $past(o_busy)
		|| $past(o_busy, 2)) else $error("result changed outside a scan");
	AST_FLAG_RES: assert property ((o_flags & ~$past(o_flags) & ~o_scan_result) == 16'h0000)
		else $error("flag set without its result bit");
	AST_START: assert property (start && ctrl[1:0] == sss_pkg::TRIG_SINGLE && !o_busy
		&& channel_enable_mask != 16'h0000 |-> ##[1:12] o_busy) else $error("no scan after start");
	AST_RST: assert property ($past(i_reset) |-> &o_ch_pins.oe_n && !o_busy)
		else $error("pins driven after reset");
	AST_PAIR: assert property (o_cmp_en == 2'b11 |-> ctrl[3])
		else $error("both comparators without paired mode");
	AST_CMP_BUSY: assert property (o_cmp_en != 2'b00 |-> o_busy || $past(o_busy)
		|| $past(o_busy, 2)) else $error("comparator in use while idle");
endmodule
`default_nettype wire

// file: tb/sss_scan_seq_tb.sv
// sss_scan_seq_tb: self-checking bench for the sensor scan sequencer.
// assumes sss_cmp_model as comparators and the checker bound below.
`timescale 1ns/1ns
`default_nettype none
module sss_scan_seq_tb;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} sss_row_t;
	localparam int PT = 59;
	logic i_clk_sys = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h00000000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_reflex_event = 8'h00;
	logic [15:0] levels = 16'h0000;
	logic pulse = 1'b0;
	logic [1:0] i_cmp_out, o_cmp_en, o_dac_req;
	logic [31:0] o_rdata, v;
	sss_pkg::sss_ch_pins_t o_ch_pins;
	sss_pkg::sss_alt_pins_t o_alt_pins;
	logic [2:0] o_cmp_sel;
	logic [15:0] o_scan_result, o_flags;
	logic o_busy;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	int r1;
	int drv3 = 0;
	sss_row_t rows [7] = '{
		'{sss_pkg::OFS_PTOP, 32'h12345678, 32'h00005678},
		'{sss_pkg::OFS_TIMING, 32'hFFFF1234, 32'h00001234},
		'{sss_pkg::OFS_CMD, 32'h00000001, 32'h00000000},
		'{sss_pkg::OFS_SRES, 32'h0000FFFF, 32'h00000000},
		'{8'h30, 32'hFFFFFFFF, 32'h00000000},
		'{8'h44, 32'hFFFFFFFF, 32'h03FFFFFF},
		'{8'h84, 32'hFFFFFFFF, 32'h0000003F}};
	// ==========================================
	// design and comparators
	sss_scan_seq dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_cmp_out(i_cmp_out), .i_reflex_event(i_reflex_event), .o_ch_pins(o_ch_pins),
		.o_alt_pins(o_alt_pins), .o_cmp_sel(o_cmp_sel), .o_cmp_en(o_cmp_en),
		.o_dac_req(o_dac_req), .o_scan_result(o_scan_result), .o_flags(o_flags),
		.o_busy(o_busy));
	sss_cmp_model cmp (.i_clk_sys(i_clk_sys), .i_sel(o_cmp_sel), .i_en(o_cmp_en),
		.i_levels(levels), .i_pulse(pulse), .o_out(i_cmp_out));
	// 20 MHz clock and a cycle count
	initial begin
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) cyc <= cyc + 1;
	// count cycles with channel 3 driven high
	always @(posedge i_clk_sys) begin
		if (!o_ch_pins.oe_n[3] && o_ch_pins.level[3]) begin
			drv3 <= drv3 + 1;
		end
	end
	// ==========================================
	// tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// wait for busy to reach a level, bounded
	task automatic wait_busy(input logic lvl);
		for (int n = 0; n < 3000 && o_busy !== lvl; n++) @(posedge i_clk_sys) #1;
		check(32'(o_busy), 32'(lvl));
	endtask
	task automatic scan(input logic [15:0] m, input logic [15:0] e);
		wr(sss_pkg::OFS_CMD, 32'h00000001);
		wait_busy(1'b1);
		wait_busy(1'b0);
		repeat (6) @(posedge i_clk_sys);
		#1 check(32'(o_scan_result & m), 32'(e));
	endtask
	task automatic give_verdict();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#2000000;
		bad_count++;
		$display("BAD %0t watchdog", $time);
		give_verdict();
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (4) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		rd(sss_pkg::OFS_PTOP, v);
		check(v, 32'(sss_pkg::RST_PTOP));
		rd(sss_pkg::OFS_CLKDIV, v);
		check(v, 32'(sss_pkg::RST_CLKDIV));
		check(32'({o_alt_pins, o_dac_req}), 32'h000003FC);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, v);
			check(v, rows[i].e);
		end
		// single shot over channels 3, 5 and 9, flag on channel 3 only
		wr(sss_pkg::OFS_CLKDIV, 32'h00000000);
		wr(sss_pkg::OFS_TIMING, 32'h00000000);
		wr(sss_pkg::OFS_CTRL, 32'h00000001);
		wr(sss_pkg::OFS_CHANNEL_ENABLE_MASK, 32'h00000228);
		wr(sss_pkg::OFS_IDLE, 32'h00000000);
		wr(8'h8C, 32'h00000011);
		levels <= 16'h0028;
		scan(16'hFFFF, 16'h0028);
		check(32'(drv3), 32'h00000001);
		check(32'(o_flags), 32'h00000008);
		wr(sss_pkg::OFS_FLAGS, 32'h0000FFFF);
		check(32'(o_flags), 32'h00000000);
		// pulse counting on channel 0, ge then lt against 3
		wr(sss_pkg::OFS_CHANNEL_ENABLE_MASK, 32'h00000001);
		wr(8'h40, 32'h00280000);
		wr(8'hC0, 32'h00000003);
		pulse <= 1'b1;
		for (int g = 1; g >= 0; g--) begin
			wr(8'h80, 32'(8 + 32 * g));
			scan(16'h0001, 16'(g));
		end
		pulse <= 1'b0;
		// both comparators sampled on input 2
		wr(sss_pkg::OFS_CTRL, 32'h00000009);
		wr(sss_pkg::OFS_CHANNEL_ENABLE_MASK, 32'h00000004);
		levels <= 16'h0404;
		scan(16'h0404, 16'h0404);
		rd(sss_pkg::OFS_RESULT, v);
		check(v & 32'h00000003, 32'h00000003);
		// reflex start: arm, wrong channel, then channel 5
		wr(sss_pkg::OFS_CTRL, 32'h00000052);
		wr(sss_pkg::OFS_CHANNEL_ENABLE_MASK, 32'h00000001);
		wr(8'h80, 32'h00000000);
		levels <= 16'h0001;
		wr(sss_pkg::OFS_CMD, 32'h00000001);
		for (int e = 4; e < 6; e++) begin
			repeat (20) @(posedge i_clk_sys);
			check(32'(o_busy), 32'h00000000);
			i_reflex_event <= 8'(1 << e);
			repeat (3) @(posedge i_clk_sys);
			i_reflex_event <= 8'h00;
		end
		wait_busy(1'b1);
		wait_busy(1'b0);
		// periodic scans with an extra scan in between
		wr(sss_pkg::OFS_PTOP, 32'(PT));
		wr(sss_pkg::OFS_TIMING, 32'h00000001);
		wr(sss_pkg::OFS_CTRL, 32'h00000000);
		wait_busy(1'b1);
		wait_busy(1'b0);
		wait_busy(1'b1);
		r1 = cyc;
		wait_busy(1'b0);
		scan(16'h0001, 16'h0001);
		wait_busy(1'b1);
		check(32'(cyc - r1), 32'((1 + PT) * 2));
		give_verdict();
	end
endmodule
bind sss_scan_seq sss_scan_seq_chk chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .o_ch_pins(o_ch_pins),
	.o_cmp_en(o_cmp_en), .o_scan_result(o_scan_result), .o_flags(o_flags), .o_busy(o_busy));
`default_nettype wire
